/* sm_defs.svh */
// Constants of the supply monitor flag logic: SFR address, field positions,
// reset value, trip codes and timing counts. Assumes a 100 MHz core clock.
//
// Function
// - Digital trip select picks threshold: 00 4.63 V, 01 3.08 V, 10 2.93 V, 11 2.63 V.
// - Analog trip select uses the same four codes and thresholds.
// - Bit 7 is read-only, live digital comparator state, 1 means supply healthy.
// - Bit 6 is read-only, live analog comparator state, 1 means supply healthy.
// - Flag bit 5 sets whenever either filtered comparator output is low while enabled.
// - Both outputs high and staying high start 250 ms timer; expiry clears flag.
// - Software may write the flag; clearing fails while either comparator is low.
// - Enable bit 0 runs the monitor; writing 0 disables it.
// - Flag reaches the core as interrupt only when its enable is set.
// - Short comparator glitches are filtered and never set the flag.
// - Control register reads 0xde after power-on; not bit addressable.
// - Layout: 7 digital ok, 6 analog ok, 5 flag, 4:3 dsel, 2:1 asel, 0 enable.
`ifndef SM_DEFS_SVH
`define SM_DEFS_SVH

`define SM_CTRL_ADDR 8'hdf
`define SM_CTRL_RESET 8'hde

`define SM_BIT_DIG_OK 7
`define SM_BIT_ANA_OK 6
`define SM_BIT_FLAG 5
`define SM_DSEL_HI 4
`define SM_DSEL_LO 3
`define SM_ASEL_HI 2
`define SM_ASEL_LO 1
`define SM_BIT_EN 0

// Trip codes, shared by both rails
`define SM_TRIP_4V63 2'h0
`define SM_TRIP_3V08 2'h1
`define SM_TRIP_2V93 2'h2
`define SM_TRIP_2V63 2'h3

`define SM_CLK_MHZ 100
`define SM_HOLD_MS 250
`define SM_HOLD_CYCLES (`SM_HOLD_MS * `SM_CLK_MHZ * 1000)
`define SM_GLITCH_NS 1000
`define SM_GLITCH_CYCLES ((`SM_GLITCH_NS * `SM_CLK_MHZ + 999) / 1000)

`endif

/* sm_glitch_filter.sv */
// Glitch filter: a comparator level is accepted only after it has held
// for FILT_CYCLES clocks. Input is already registered in the core domain.
`timescale 1ns/1ps
`include "sm_defs.svh"

module sm_glitch_filter
   import sm_pkg::*;
#(
   parameter int unsigned FILT_CYCLES = `SM_GLITCH_CYCLES
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire logic level_in,
   output logic level_out
);

   sm_filt_state_t state_r;
   sm_filt_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      if (!en_in)
      begin
         state_nxt.stable = 1'b1;
         state_nxt.cnt = 7'h00;
      end
      else if (level_in == state_r.stable)
      begin
         state_nxt.cnt = 7'h00;
      end
      else if (state_r.cnt == 7'(FILT_CYCLES - 1))
      begin
         state_nxt.stable = level_in;
         state_nxt.cnt = 7'h00;
      end
      else
      begin
         state_nxt.cnt = state_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= '{stable: 1'b1, cnt: 7'h00};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign level_out = state_r.stable;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_one_cycle_blip;
      en_in && (level_in != level_out) ##1 (level_in == level_out);
   endsequence

   property p_glitch_ignored;
      s_one_cycle_blip |-> ##1 $stable(level_out) [*3];
   endproperty
   a_glitch_ignored: assert property (p_glitch_ignored) else $error("short glitch passed filter");

endmodule // sm_glitch_filter

/* sm_hold_timer.sv */
// Recovery timer: counts while run_in is high, pulses expire_out once
// every HOLD_CYCLES clocks. Dropping run_in discards the count.
`timescale 1ns/1ps
`include "sm_defs.svh"

module sm_hold_timer
   import sm_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `SM_HOLD_CYCLES
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   output logic expire_out
);

   sm_tmr_state_t state_r;
   sm_tmr_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      state_nxt.expire = 1'b0;
      if (!run_in)
      begin
         state_nxt.cnt = 25'h0000000;
      end
      else if (state_r.cnt == 25'(HOLD_CYCLES - 1))
      begin
         state_nxt.cnt = 25'h0000000;
         state_nxt.expire = 1'b1;
      end
      else
      begin
         state_nxt.cnt = state_r.cnt + 25'h0000001;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= '{cnt: 25'h0000000, expire: 1'b0};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign expire_out = state_r.expire;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_restart_on_drop;
      !run_in |=> (state_r.cnt == 25'h0000000) && !expire_out;
   endproperty
   a_restart_on_drop: assert property (p_restart_on_drop) else $error("count kept after rail drop");

   property p_expire_after_full_count;
      expire_out |-> $past(run_in) && ($past(state_r.cnt) == 25'(HOLD_CYCLES - 1));
   endproperty
   a_expire_after_full_count: assert property (p_expire_after_full_count) else $error("early expiry");

endmodule // sm_hold_timer

/* sm_pkg.sv */
// Types of the supply monitor flag logic.
// Assumes nothing of its surroundings.
package sm_pkg;

   // Core SFR access, one request per cycle
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sm_sfr_req_t;

   // Writable and sticky part of the control register
   typedef struct packed {
      logic flag;
      logic [1:0] dsel;
      logic [1:0] asel;
      logic en;
   } sm_ctrl_t;

   typedef struct packed {
      logic dig_smp;
      logic ana_smp;
      sm_ctrl_t ctrl;
      logic [7:0] rdata;
      logic irq;
   } sm_top_state_t;

   typedef struct packed {
      logic stable;
      logic [6:0] cnt;
   } sm_filt_state_t;

   typedef struct packed {
      logic [24:0] cnt;
      logic expire;
   } sm_tmr_state_t;

endpackage

/* sm_rail_model.sv */
// Behavioural model of both supply comparators beside the monitor.
// Assumes rail voltages in millivolts; a comparator is combinational.
`timescale 1ns/1ps

module sm_rail_model
   import sm_pkg::*;
(
   input wire logic [12:0] dig_mv_in,
   input wire logic [12:0] ana_mv_in,
   input wire logic [1:0] dig_sel_in,
   input wire logic [1:0] ana_sel_in,
   output logic dig_ok_out,
   output logic ana_ok_out
);
   // ==========================================
   // Trip thresholds
   function automatic logic [12:0] trip_mv(input logic [1:0] sel);
      case (sel)
         2'h0: trip_mv = 13'h1216;
         2'h1: trip_mv = 13'hc08;
         2'h2: trip_mv = 13'hb72;
         default: trip_mv = 13'ha46;
      endcase
   endfunction

   assign dig_ok_out = dig_mv_in > trip_mv(dig_sel_in);
   assign ana_ok_out = ana_mv_in > trip_mv(ana_sel_in);
endmodule // sm_rail_model

/* sm_supply_monitor.sv */
// Supply monitor flag logic: control SFR, comparator sampling, sticky
// low-supply flag with 250 ms recovery, interrupt request to the core.
// Assumes comparator outputs and SFR requests are synchronous to CLK_IN.
`timescale 1ns/1ps
`include "sm_defs.svh"

module sm_supply_monitor
   import sm_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `SM_HOLD_CYCLES
)
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire sm_sfr_req_t SFR_REQ_IN,
   input wire logic DIGITAL_CMP_IN,
   input wire logic ANALOG_CMP_IN,
   input wire logic IRQ_ENABLE_IN,
   output logic [7:0] SFR_RDATA_OUT,
   output logic IRQ_OUT,
   output logic [1:0] DIGITAL_TRIP_SEL_OUT,
   output logic [1:0] ANALOG_TRIP_SEL_OUT,
   output logic MONITOR_EN_OUT
);

   // ==========================================================
   // State and helpers
   // ==========================================================
   sm_top_state_t state_r;
   sm_top_state_t state_nxt;

   logic dig_filt;
   logic ana_filt;
   logic hold_expire;
   logic hold_run;
   logic wr_hit;
   logic rd_hit;
   logic rails_low;
   logic set_evt;
   logic dig_live;
   logic ana_live;
   logic [7:0] ctrl_byte;

   localparam sm_top_state_t RESET_STATE = '{
      dig_smp: 1'b1,
      ana_smp: 1'b1,
      ctrl: '{
         flag: 1'(`SM_CTRL_RESET >> `SM_BIT_FLAG),
         dsel: 2'(`SM_CTRL_RESET >> `SM_DSEL_LO),
         asel: 2'(`SM_CTRL_RESET >> `SM_ASEL_LO),
         en: 1'(`SM_CTRL_RESET >> `SM_BIT_EN)
      },
      rdata: 8'h00,
      irq: 1'b0
   };

   // ==========================================================
   // Glitch filters and recovery timer
   // ==========================================================
   sm_glitch_filter u_dig_filt
   (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .en_in(state_r.ctrl.en),
      .level_in(state_r.dig_smp),
      .level_out(dig_filt)
   );

   sm_glitch_filter u_ana_filt
   (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .en_in(state_r.ctrl.en),
      .level_in(state_r.ana_smp),
      .level_out(ana_filt)
   );

   // Count only while flag is up and both rails read healthy
   assign hold_run = state_r.ctrl.en && state_r.ctrl.flag && !rails_low;

   sm_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold
   (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .run_in(hold_run),
      .expire_out(hold_expire)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      wr_hit = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == `SM_CTRL_ADDR);
      rd_hit = SFR_REQ_IN.rd && (SFR_REQ_IN.addr == `SM_CTRL_ADDR);
      // Raw or filtered low blocks a software clear
      rails_low = state_r.ctrl.en &&
                  (!dig_filt || !ana_filt || !state_r.dig_smp || !state_r.ana_smp);
      set_evt = state_r.ctrl.en && (!dig_filt || !ana_filt);
      // Comparators are off while disabled, bits then read healthy
      dig_live = state_r.ctrl.en ? state_r.dig_smp : 1'b1;
      ana_live = state_r.ctrl.en ? state_r.ana_smp : 1'b1;
      ctrl_byte = {dig_live, ana_live, state_r.ctrl.flag, state_r.ctrl.dsel,
                   state_r.ctrl.asel, state_r.ctrl.en};

      state_nxt = state_r;
      state_nxt.dig_smp = DIGITAL_CMP_IN;
      state_nxt.ana_smp = ANALOG_CMP_IN;

      if (hold_expire)
      begin
         state_nxt.ctrl.flag = 1'b0;
      end
      if (wr_hit)
      begin
         state_nxt.ctrl.dsel = SFR_REQ_IN.wdata[`SM_DSEL_HI:`SM_DSEL_LO];
         state_nxt.ctrl.asel = SFR_REQ_IN.wdata[`SM_ASEL_HI:`SM_ASEL_LO];
         state_nxt.ctrl.en = SFR_REQ_IN.wdata[`SM_BIT_EN];
         if (SFR_REQ_IN.wdata[`SM_BIT_FLAG])
         begin
            state_nxt.ctrl.flag = 1'b1;
         end
         else if (!rails_low)
         begin
            state_nxt.ctrl.flag = 1'b0;
         end
      end
      // Hardware set wins over any clear in the same cycle
      if (set_evt)
      begin
         state_nxt.ctrl.flag = 1'b1;
      end

      state_nxt.rdata = rd_hit ? ctrl_byte : 8'h00;
      state_nxt.irq = state_r.ctrl.flag && IRQ_ENABLE_IN;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         state_r <= RESET_STATE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign SFR_RDATA_OUT = state_r.rdata;
   assign IRQ_OUT = state_r.irq;
   assign DIGITAL_TRIP_SEL_OUT = state_r.ctrl.dsel;
   assign ANALOG_TRIP_SEL_OUT = state_r.ctrl.asel;
   assign MONITOR_EN_OUT = state_r.ctrl.en;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   property p_por_value;
      !$past(RST_N_IN) |-> (ctrl_byte == `SM_CTRL_RESET) && (SFR_RDATA_OUT == 8'h00) && !IRQ_OUT;
   endproperty
   a_por_value: assert property (p_por_value) else $error("wrong power-on value");

   sequence s_ctrl_read;
      rd_hit;
   endsequence

   property p_read_dig_bit;
      s_ctrl_read |=> SFR_RDATA_OUT[`SM_BIT_DIG_OK] == ($past(state_r.ctrl.en) ? $past(state_r.dig_smp) : 1'b1);
   endproperty
   a_read_dig_bit: assert property (p_read_dig_bit) else $error("digital ok bit wrong");

   property p_read_ana_bit;
      s_ctrl_read |=> SFR_RDATA_OUT[`SM_BIT_ANA_OK] == ($past(state_r.ctrl.en) ? $past(state_r.ana_smp) : 1'b1);
   endproperty
   a_read_ana_bit: assert property (p_read_ana_bit) else $error("analog ok bit wrong");

   property p_dig_trip_write;
      wr_hit |=> DIGITAL_TRIP_SEL_OUT == $past(SFR_REQ_IN.wdata[4:3]);
   endproperty
   a_dig_trip_write: assert property (p_dig_trip_write) else $error("digital trip select not stored");

   property p_ana_trip_write;
      wr_hit |=> ANALOG_TRIP_SEL_OUT == $past(SFR_REQ_IN.wdata[2:1]);
   endproperty
   a_ana_trip_write: assert property (p_ana_trip_write) else $error("analog trip select not stored");

   property p_flag_sets_on_low;
      state_r.ctrl.en && !dig_filt |=> state_r.ctrl.flag ##1 IRQ_OUT == $past(IRQ_ENABLE_IN);
   endproperty
   a_flag_sets_on_low: assert property (p_flag_sets_on_low) else $error("flag not set on low rail");

   property p_clear_blocked;
      wr_hit && !SFR_REQ_IN.wdata[5] && state_r.ctrl.flag && rails_low |=> state_r.ctrl.flag;
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared while rail low");

   property p_disabled_quiet;
      !state_r.ctrl.en && !state_r.ctrl.flag && !wr_hit |=>
         !state_r.ctrl.flag ##1 (!state_r.ctrl.flag || $past(wr_hit));
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while disabled");

   property p_irq_gate;
      ##1 IRQ_OUT == ($past(state_r.ctrl.flag) && $past(IRQ_ENABLE_IN));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enable");

   property p_auto_clear;
      hold_expire && !set_evt && !wr_hit |=> !state_r.ctrl.flag;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("flag not cleared at expiry");

   // ==========================================================
   // Register view, flag life and timer assertions
   // ==========================================================
   sequence s_sw_clear;
      wr_hit && !SFR_REQ_IN.wdata[`SM_BIT_FLAG];
   endsequence

   sequence s_rail_fault;
      state_r.ctrl.en && (!dig_filt || !ana_filt);
   endsequence

   sequence s_expire_clean;
      hold_expire && !set_evt && !wr_hit;
   endsequence

   property p_rdata_idle;
      !rd_hit |=> SFR_RDATA_OUT == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   property p_read_flag;
      s_ctrl_read |=> SFR_RDATA_OUT[`SM_BIT_FLAG] == $past(state_r.ctrl.flag);
   endproperty
   a_read_flag: assert property (p_read_flag) else $error("flag bit read wrong");

   property p_read_fields;
      s_ctrl_read |=>
         SFR_RDATA_OUT[`SM_DSEL_HI:`SM_BIT_EN] == $past({state_r.ctrl.dsel, state_r.ctrl.asel, state_r.ctrl.en});
   endproperty
   a_read_fields: assert property (p_read_fields) else $error("select or enable bits read wrong");

   property p_en_write;
      wr_hit |=> MONITOR_EN_OUT == $past(SFR_REQ_IN.wdata[`SM_BIT_EN]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable not stored");

   property p_sw_set;
      wr_hit && SFR_REQ_IN.wdata[`SM_BIT_FLAG] |=> state_r.ctrl.flag;
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");

   property p_sw_clear;
      s_sw_clear ##0 (!rails_low && !set_evt) |=> !state_r.ctrl.flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("allowed clear of flag ignored");

   property p_fault_holds_flag;
      s_rail_fault |=> state_r.ctrl.flag && !hold_expire;
   endproperty
   a_fault_holds_flag: assert property (p_fault_holds_flag) else $error("fault did not hold flag");

   property p_no_expiry_while_low;
      rails_low |=> !hold_expire;
   endproperty
   a_no_expiry_while_low: assert property (p_no_expiry_while_low) else $error("timer expired with rail low");

   property p_flag_sticky;
      state_r.ctrl.flag && !hold_expire && !wr_hit |=> state_r.ctrl.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without cause");

   property p_no_spurious_set;
      !state_r.ctrl.flag && !set_evt && !wr_hit |=> !state_r.ctrl.flag;
   endproperty
   a_no_spurious_set: assert property (p_no_spurious_set) else $error("flag rose without filtered low");

   property p_off_reads_ok;
      s_ctrl_read ##0 !state_r.ctrl.en |=> SFR_RDATA_OUT[`SM_BIT_DIG_OK:`SM_BIT_ANA_OK] == 2'h3;
   endproperty
   a_off_reads_ok: assert property (p_off_reads_ok) else $error("comparator bits low while off");

   property p_recovery_irq;
      s_expire_clean |=> !state_r.ctrl.flag ##1 !IRQ_OUT;
   endproperty
   a_recovery_irq: assert property (p_recovery_irq) else $error("interrupt kept after recovery");

   property p_irq_masked;
      !IRQ_ENABLE_IN |=> !IRQ_OUT;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked");

   property p_ctrl_hold;
      !wr_hit |=> $stable(DIGITAL_TRIP_SEL_OUT) && $stable(ANALOG_TRIP_SEL_OUT) && $stable(MONITOR_EN_OUT);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control fields changed without write");

endmodule // sm_supply_monitor

/* testbench.sv */
// Self-checking bench of the supply monitor flag logic.
// Assumes the comparator model and a short recovery count of 20 cycles.
`timescale 1ns/1ps
`include "sm_defs.svh"

module testbench
   import sm_pkg::*;
;
   localparam logic [12:0] MV_HI = 13'h1388;
   localparam logic [12:0] MV_MID = 13'hbb8;
   localparam logic [12:0] MV_LOW = 13'h7d0;
   logic clk;
   logic rst_n;
   sm_sfr_req_t req;
   logic irq_en;
   logic dig_ok;
   logic ana_ok;
   logic [7:0] rdata;
   logic irq;
   logic [1:0] dsel;
   logic [1:0] asel;
   logic mon_en;
   logic [12:0] dig_mv;
   logic [12:0] ana_mv;
   logic [7:0] v;
   int errors;
   int checks;
   int cycles;
   int i;

   sm_supply_monitor #(.HOLD_CYCLES(20)) DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .SFR_REQ_IN(req),
      .DIGITAL_CMP_IN(dig_ok), .ANALOG_CMP_IN(ana_ok), .IRQ_ENABLE_IN(irq_en), .SFR_RDATA_OUT(rdata),
      .IRQ_OUT(irq), .DIGITAL_TRIP_SEL_OUT(dsel), .ANALOG_TRIP_SEL_OUT(asel), .MONITOR_EN_OUT(mon_en));

   sm_rail_model rails (.dig_mv_in(dig_mv), .ana_mv_in(ana_mv), .dig_sel_in(dsel), .ana_sel_in(asel),
      .dig_ok_out(dig_ok), .ana_ok_out(ana_ok));

   // ==========================================
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         report_and_stop();
      end
   end

   // ==========================================
   // Tasks
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic sfr_write(input logic [7:0] d);
      @(posedge clk);
      #1;
      req.addr = `SM_CTRL_ADDR;
      req.wdata = d;
      req.wr = 1'b1;
      @(posedge clk);
      #1;
      req.wr = 1'b0;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      req.addr = a;
      req.rd = 1'b1;
      @(posedge clk);
      #1;
      req.rd = 1'b0;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] exp);
      logic [7:0] d;
      sfr_read(`SM_CTRL_ADDR, d);
      check(d, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      req = '0;
      irq_en = 1'b1;
      dig_mv = MV_HI;
      ana_mv = MV_HI;
      rst_n = 1'b0;
      errors = 0;
      checks = 0;
      cycles = 0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd_chk(8'hde);
      check({4'h0, dsel, asel}, 8'h0f);
      check({6'h00, mon_en, irq}, 8'h00);
      sfr_read(8'hde, v);
      check(v, 8'h00);
      sfr_write(8'h01);
      rd_chk(8'hc1);
      check({5'h00, dsel, mon_en}, 8'h01);
      dig_mv = MV_MID;
      wait_cyc(1);
      dig_mv = MV_HI;
      wait_cyc(5);
      dig_mv = MV_MID;
      wait_cyc(50);
      dig_mv = MV_HI;
      wait_cyc(110);
      rd_chk(8'hc1);
      dig_mv = MV_MID;
      wait_cyc(130);
      rd_chk(8'h61);
      check({7'h00, irq}, 8'h01);
      irq_en = 1'b0;
      wait_cyc(2);
      check({7'h00, irq}, 8'h00);
      irq_en = 1'b1;
      sfr_write(8'h01);
      rd_chk(8'h61);
      dig_mv = MV_HI;
      wait_cyc(112);
      ana_mv = MV_MID;
      wait_cyc(5);
      ana_mv = MV_HI;
      wait_cyc(15);
      rd_chk(8'he1);
      v = 8'hff;
      for (i = 0; i < 4 && v[5] !== 1'b0; i++)
         sfr_read(`SM_CTRL_ADDR, v);
      check(v, 8'hc1);
      wait_cyc(2);
      check({7'h00, irq}, 8'h00);
      sfr_write(8'h21);
      rd_chk(8'he1);
      sfr_write(8'h01);
      rd_chk(8'hc1);
      dig_mv = MV_MID;
      ana_mv = MV_MID;
      for (i = 0; i < 4; i++)
      begin
         sfr_write({3'h0, i[1:0], i[1:0], 1'b1});
         wait_cyc(110);
         sfr_read(`SM_CTRL_ADDR, v);
         check({6'h00, v[7:6]}, (i >= 2) ? 8'h03 : 8'h00);
         check({4'h0, dsel, asel}, {4'h0, i[1:0], i[1:0]});
      end
      sfr_write(8'h00);
      dig_mv = MV_LOW;
      wait_cyc(130);
      rd_chk(8'hc0);
      check({6'h00, mon_en, irq}, 8'h00);
      report_and_stop();
   end
endmodule // testbench
